// file: rtl/bst_tap_top.sv
// boundary-scan test access port: state machine, instruction and data paths
//
// Notes on behaviour
// - The serial test port follows the standard test access port protocol and states.
// - Boundary, pass, identity and debug data registers exist, chosen by the instruction.
// - All shift paths sit in parallel between the one serial input and the one output.
// - Pass and boundary paths take serial input at the top bit and output the bottom bit.
// - A selected data register moves exactly one bit per rising test clock while shifting.
// - The boundary chain holds a cell for every input and output pin, plus one shared control cell.
// - Data leaves the boundary chain uninverted, as it entered.
// - Boundary capture and update act only under external-test or sample/preload.
// - The pass register delays serial data by exactly one test clock.
// - A 32-bit identity register is readable over the serial path.
// - A 38-bit debug register exchanges command, status and data with the processor.
// - Besides the five test pins there are four debug pins.
// - The instruction register is 4 bits, bottom bit out first, reset to identity read.
// - Code 0010 selects the identity register, whose stored value never changes.
// - Code 1111 selects the pass register, so an all-ones scan gives bypass.
// - Code 0101 selects the debug register and enables the four debug pins.
`timescale 1ns/100ps
module bst_tap_top #(
  parameter int          N_IN     = 8,
  parameter int          N_OUT    = 8,
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // arbitrary value, bit 0 set
) (
  // system clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // serial test link pins
  input  wire logic                     tck,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  input  wire logic                     trst_b,
  output logic                          tdo,
  output logic                          tdo_oe,
  // device pins behind the boundary cells
  input  wire logic [N_IN-1:0]          pad_in,
  output logic [N_OUT-1:0]              pad_out,
  output logic [N_OUT-1:0]              pad_oe,
  // on-chip system logic side of the cells
  input  wire logic [N_OUT-1:0]         sys_out,
  input  wire logic                     sys_oe,
  output logic [N_IN-1:0]               sys_in,
  // debug pins
  output logic                          debug_command_ack,
  output logic                          debug_command_ack_oe,
  input  wire logic                     break_request_trace_capture,
  output logic                          stop_transmit,
  output logic                          stop_transmit_oe,
  output logic                          trigger_trace_out,
  output logic                          trigger_trace_oe,
  // processor debug logic side
  input  wire logic [bst_pkg::DBG_W-1:0] dbg_status,
  input  wire logic                     cpu_cmd_ack,
  input  wire logic                     cpu_stop,
  input  wire logic                     cpu_trigger,
  output logic [bst_pkg::DBG_W-1:0]     dbg_cmd,
  output logic                          dbg_cmd_valid,
  output logic                          dbg_break_req
);
  import bst_pkg::*;

  localparam int BSC_W = N_IN + N_OUT + 1;

  // next state of the test state machine from mode select
  function automatic bst_state_t bst_next(input bst_state_t s, input logic m);
    bst_state_t n;
    n = BST_RESET;
    case (s)
      BST_RESET:  n = m ? BST_RESET  : BST_IDLE;
      BST_IDLE:   n = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: n = m ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: n = m ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR:  n = m ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: n = m ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR:  n = m ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: n = m ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: n = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: n = m ? BST_RESET  : BST_CAP_IR;
      BST_CAP_IR: n = m ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR:  n = m ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: n = m ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR:  n = m ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: n = m ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: n = m ? BST_SEL_DR : BST_IDLE;
      default:    n = BST_RESET;
    endcase
    return n;
  endfunction

  // pin synchronisers; stage one is read only by stage two
  logic [SYNC_STAGES-1:0] tck_sync;
  logic                   tck_prev;
  logic [SYNC_STAGES-1:0] tms_sync;
  logic [SYNC_STAGES-1:0] tdi_sync;
  logic [SYNC_STAGES-1:0] trst_sync;
  logic [SYNC_STAGES-1:0] brk_sync;
  logic [N_IN-1:0]        pad_sync1;
  logic [N_IN-1:0]        pad_sync2;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_sync  <= '0;
      tck_prev  <= 1'b0;
      tms_sync  <= '1;
      tdi_sync  <= '1;
      trst_sync <= '0;
      brk_sync  <= '0;
      pad_sync1 <= '0;
      pad_sync2 <= '0;
    end else begin
      tck_sync  <= {tck_sync[0], tck};
      tck_prev  <= tck_sync[1];
      tms_sync  <= {tms_sync[0], tms};
      tdi_sync  <= {tdi_sync[0], tdi};
      trst_sync <= {trst_sync[0], trst_b};
      brk_sync  <= {brk_sync[0], break_request_trace_capture};
      pad_sync1 <= pad_in;
      pad_sync2 <= pad_sync1;
    end
  end

  // test clock edges, found by the system clock
  wire tck_rise = tck_sync[1] & ~tck_prev;
  wire tck_fall = ~tck_sync[1] & tck_prev;
  wire tms_s    = tms_sync[1];
  wire tdi_s    = tdi_sync[1];
  wire trst_on  = ~trst_sync[1];

  bst_state_t  state;
  bst_state_t  next_state;
  logic [3:0]  ir;
  logic [3:0]  ir_shift;
  logic        pass_bit;
  logic [31:0] id_shift;
  logic [DBG_W-1:0] dbg_shift;

  assign next_state = bst_next(state, tms_s);

  // state machine; test reset wins over any clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= BST_RESET;
    end else if (trst_on) begin
      state <= BST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction decode; reserved codes fall back to the pass register
  wire sel_bsc  = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  wire sel_id   = (ir == IR_IDENT);
  wire sel_dbg  = (ir == IR_DEBUG);
  wire sel_pass = ~(sel_bsc | sel_id | sel_dbg);
  wire extest   = (ir == IR_EXTEST);
  wire floating = (ir == IR_FLOAT);

  // shared strobes for every data path, one clk cycle each
  wire cap_dr = tck_rise & (state == BST_CAP_DR);
  wire sh_dr  = tck_rise & (state == BST_SH_DR);
  wire upd_dr = tck_fall & (state == BST_UPD_DR);

  // instruction path: capture fixed pattern, shift, update on falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift <= IR_CAPTURE;
      ir       <= IR_RESET_VAL;
    end else begin
      if (tck_rise && state == BST_CAP_IR) begin
        ir_shift <= IR_CAPTURE;
      end else if (tck_rise && state == BST_SH_IR) begin
        ir_shift <= {tdi_s, ir_shift[3:1]};
      end
      if (state == BST_RESET) begin
        ir <= IR_RESET_VAL;
      end else if (tck_fall && state == BST_UPD_IR) begin
        ir <= ir_shift;
      end
    end
  end

  // pass register: one stage, so one test clock of delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_bit <= BYPASS_CAPTURE;
    end else if (cap_dr && sel_pass) begin
      pass_bit <= BYPASS_CAPTURE;
    end else if (sh_dr && sel_pass) begin
      pass_bit <= tdi_s;
    end
  end

  // identity path shifts a copy; the constant itself is never written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      id_shift <= ID_VALUE;
    end else if (cap_dr && sel_id) begin
      id_shift <= ID_VALUE;
    end else if (sh_dr && sel_id) begin
      id_shift <= {tdi_s, id_shift[ID_W-1:1]};
    end
  end

  // debug path: status in at capture, command out at update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dbg_shift     <= '0;
      dbg_cmd       <= '0;
      dbg_cmd_valid <= 1'b0;
    end else begin
      dbg_cmd_valid <= 1'b0;
      if (cap_dr && sel_dbg) begin
        dbg_shift <= dbg_status;
      end else if (sh_dr && sel_dbg) begin
        dbg_shift <= {tdi_s, dbg_shift[DBG_W-1:1]};
      end
      if (upd_dr && sel_dbg) begin
        dbg_cmd       <= dbg_shift;
        dbg_cmd_valid <= 1'b1;
      end
    end
  end

  // boundary cells: inputs low, outputs above, one control cell on top
  wire [BSC_W-1:0] bsc_capture = {~sys_oe, sys_out, pad_sync2};
  wire [BSC_W-1:0] bsc_update;
  wire             bsc_so;

  bst_boundary_chain #(
    .WIDTH        (BSC_W)
  ) u_chain (
    .clk          (clk),
    .rst_b        (rst_b),
    .capture_en   (cap_dr & sel_bsc),
    .shift_en     (sh_dr & sel_bsc),
    .update_en    (upd_dr & sel_bsc),
    .serial_in    (tdi_s),
    .serial_out   (bsc_so),
    .capture_data (bsc_capture),
    .update_data  (bsc_update)
  );

  // serial output select; all paths share the one output pin
  wire dr_out = sel_bsc ? bsc_so :
                sel_id  ? id_shift[0] :
                sel_dbg ? dbg_shift[0] : pass_bit;
  wire tdo_sel = (state == BST_SH_IR) ? ir_shift[0] : dr_out;
  wire shifting = (state == BST_SH_IR) || (state == BST_SH_DR);

  // output changes on falling edge so the far end samples a settled bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo    <= TDO_RESET;
      tdo_oe <= 1'b0;
    end else if (trst_on) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= tdo_sel;
      tdo_oe <= shifting;
    end
  end

  // pin drivers: test pattern under external test, float under float code
  wire ctrl_cell             = bsc_update[BSC_W-1];
  wire [N_OUT-1:0] next_pout = extest ? bsc_update[N_IN +: N_OUT] : sys_out;
  wire next_poe              = floating ? 1'b0 : (extest ? ~ctrl_cell : sys_oe);

  // registered so every pin leaves a flop; system never sees latched test inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= '0;
      pad_oe  <= '0;
      sys_in  <= '0;
    end else begin
      pad_out <= next_pout;
      pad_oe  <= {N_OUT{next_poe}};
      sys_in  <= pad_sync2;
    end
  end

  // debug pins only come alive under the debug instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_command_ack    <= 1'b0;
      debug_command_ack_oe <= 1'b0;
      stop_transmit        <= 1'b0;
      stop_transmit_oe     <= 1'b0;
      trigger_trace_out    <= 1'b0;
      trigger_trace_oe     <= 1'b0;
      dbg_break_req        <= 1'b0;
    end else begin
      debug_command_ack    <= sel_dbg & cpu_cmd_ack;
      debug_command_ack_oe <= sel_dbg;
      stop_transmit        <= sel_dbg & cpu_stop;
      stop_transmit_oe     <= sel_dbg;
      trigger_trace_out    <= sel_dbg & cpu_trigger;
      trigger_trace_oe     <= sel_dbg;
      dbg_break_req        <= sel_dbg & brk_sync[1];
    end
  end

endmodule

// file: common/bst_pkg.sv
// constants, codes and state encodings shared by the boundary-scan test port
package bst_pkg;

  // instruction register geometry and codes
  localparam int          IR_W          = 4;
  localparam logic [3:0]  IR_EXTEST     = 4'h0;
  localparam logic [3:0]  IR_SAMPLE     = 4'h1;
  localparam logic [3:0]  IR_IDENT      = 4'h2;
  localparam logic [3:0]  IR_FLOAT      = 4'h3;
  localparam logic [3:0]  IR_DEBUG      = 4'h5;
  localparam logic [3:0]  IR_BYPASS     = 4'hf;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;
  localparam logic [3:0]  IR_RESET_VAL  = IR_IDENT;

  // data register widths
  localparam int          ID_W          = 32;
  localparam int          DBG_W         = 38;

  // pin synchroniser depth and reset values
  localparam int          SYNC_STAGES   = 2;
  localparam logic        TDO_RESET     = 1'b0;
  localparam logic        BYPASS_CAPTURE = 1'b0;

  // test state machine, one-hot
  typedef enum logic [15:0] {
    BST_RESET    = 16'h0001,
    BST_IDLE     = 16'h0002,
    BST_SEL_DR   = 16'h0004,
    BST_CAP_DR   = 16'h0008,
    BST_SH_DR    = 16'h0010,
    BST_EX1_DR   = 16'h0020,
    BST_PA_DR    = 16'h0040,
    BST_EX2_DR   = 16'h0080,
    BST_UPD_DR   = 16'h0100,
    BST_SEL_IR   = 16'h0200,
    BST_CAP_IR   = 16'h0400,
    BST_SH_IR    = 16'h0800,
    BST_EX1_IR   = 16'h1000,
    BST_PA_IR    = 16'h2000,
    BST_EX2_IR   = 16'h4000,
    BST_UPD_IR   = 16'h8000
  } bst_state_t;

endpackage

// file: rtl/bst_boundary_chain.sv
// boundary cell chain: capture, shift and update stages of every pin cell
`timescale 1ns/100ps
module bst_boundary_chain #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // stage strobes, one clk cycle each
  input  wire logic             capture_en,
  input  wire logic             shift_en,
  input  wire logic             update_en,
  // serial path
  input  wire logic             serial_in,
  output logic                  serial_out,
  // parallel sides
  input  wire logic [WIDTH-1:0] capture_data,
  output logic [WIDTH-1:0]      update_data
);

  logic [WIDTH-1:0] shift_stage;

  // shift stage: serial data enters at the top, leaves at bit 0 uninverted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_stage <= '0;
    end else if (capture_en) begin
      shift_stage <= capture_data;
    end else if (shift_en) begin
      shift_stage <= {serial_in, shift_stage[WIDTH-1:1]};
    end
  end

  // update stage holds pin values steady while the next pattern shifts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      update_data <= '0;
    end else if (update_en) begin
      update_data <= shift_stage;
    end
  end

  assign serial_out = shift_stage[0];

endmodule

// file: verification/bst_tap_asserts.sv
// concurrent checks on the boundary-scan test port pins
`timescale 1ns/100ps
module bst_tap_asserts #(
  parameter int N_IN  = 8,
  parameter int N_OUT = 8
) (
  // clock, reset and link
  input wire logic                      clk,
  input wire logic                      rst_b,
  input wire logic                      tck,
  input wire logic                      tdo,
  // system pins
  input wire logic [N_IN-1:0]           pad_in,
  input wire logic [N_IN-1:0]           sys_in,
  // debug pins and processor side
  input wire logic                      debug_command_ack,
  input wire logic                      debug_command_ack_oe,
  input wire logic                      stop_transmit,
  input wire logic                      stop_transmit_oe,
  input wire logic                      trigger_trace_oe,
  input wire logic                      cpu_cmd_ack,
  input wire logic                      cpu_stop,
  input wire logic [bst_pkg::DBG_W-1:0] dbg_cmd,
  input wire logic                      dbg_cmd_valid
);
  import bst_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // debug pins copy the processor only while enabled
  a_ack_follow: assert property (
    debug_command_ack_oe && $past(debug_command_ack_oe) |-> debug_command_ack == $past(cpu_cmd_ack))
    else $error("ack pin does not follow processor");
  a_stop_follow: assert property (
    stop_transmit_oe && $past(stop_transmit_oe) |-> stop_transmit == $past(cpu_stop))
    else $error("stop pin does not follow processor");
  a_pin_oe_same: assert property (
    debug_command_ack_oe == stop_transmit_oe && trigger_trace_oe == stop_transmit_oe)
    else $error("debug pin enables differ");
  // command handover is a single pulse, only in debug mode
  a_valid_pulse: assert property (
    dbg_cmd_valid |=> !dbg_cmd_valid)
    else $error("command valid longer than one cycle");
  a_cmd_load: assert property (
    !$stable(dbg_cmd) |-> dbg_cmd_valid)
    else $error("command changed without valid");
  a_valid_debug: assert property (
    dbg_cmd_valid |-> debug_command_ack_oe)
    else $error("command valid outside debug mode");
  // test values never reach the system, pins pass after sync delay
  a_sys_in_pad: assert property (
    $stable(pad_in) [*4] |-> sys_in == pad_in)
    else $error("system input differs from pad");
  // serial output only moves after a falling test clock
  a_tdo_after_fall: assert property (
    !$stable(tdo) |-> !$past(tck, 2))
    else $error("tdo moved with test clock high");
endmodule

bind bst_tap_top bst_tap_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chk (
  .clk, .rst_b, .tck, .tdo, .pad_in, .sys_in, .debug_command_ack,
  .debug_command_ack_oe, .stop_transmit, .stop_transmit_oe, .trigger_trace_oe,
  .cpu_cmd_ack, .cpu_stop, .dbg_cmd, .dbg_cmd_valid);

// file: verification/bst_tester.sv
// external test controller model driving the serial test link
`timescale 1ns/100ps
module bst_tester (
  // serial test link
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trst_b,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic smp;
  int   oe_cnt;
  // clock still between frames, released data line pulled high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_b = 1'b1;
  end

  // one link clock; tdo taken just ahead of the rise
  // non-blocking so an edge that lands on a clk edge is seen a cycle late, never raced
  task automatic tick(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    #32;
    smp = tdo;
    if (tdo_oe === 1'b1) oe_cnt++;
    tck <= 1'b1;
    #32;
    tck <= 1'b0;
  endtask

  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    oe_cnt = 0;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = smp;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask

  // test reset with the link clock held low
  task automatic pulse_reset();
    trst_b <= 1'b0;
    #50;
    trst_b <= 1'b1;
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module testbench;
  import bst_pkg::*;
  localparam int          NI     = 4;
  localparam int          NO     = 4;
  localparam int          L      = NI + NO + 1;
  localparam logic [31:0] ID_VAL = 32'h1234_5679; // arbitrary value, bit 0 set
  logic             clk, rst_b, tck, tms, tdi, trst_b, tdo, tdo_oe, sys_oe, brk;
  logic             ack, ack_oe, stp, stp_oe, trg, trg_oe, c_ack, c_stp, c_trg, dval, dbrk;
  logic [NI-1:0]    pad_in, sys_in;
  logic [NO-1:0]    pad_out, pad_oe, sys_out;
  logic [DBG_W-1:0] dstat, dcmd;
  logic [63:0]      d, q, r;
  int               seed = 32'h52d3688d;
  int               error_cnt = 0;
  int               samples_checked = 0;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  bst_tap_top #(.N_IN(NI), .N_OUT(NO), .ID_VALUE(ID_VAL)) dut (
    .clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
    .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .sys_out(sys_out), .sys_oe(sys_oe), .sys_in(sys_in), .debug_command_ack(ack),
    .debug_command_ack_oe(ack_oe), .break_request_trace_capture(brk),
    .stop_transmit(stp), .stop_transmit_oe(stp_oe), .trigger_trace_out(trg),
    .trigger_trace_oe(trg_oe), .dbg_status(dstat), .cpu_cmd_ack(c_ack),
    .cpu_stop(c_stp), .cpu_trigger(c_trg), .dbg_cmd(dcmd), .dbg_cmd_valid(dval),
    .dbg_break_req(dbrk));
  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo),
                     .tdo_oe(tdo_oe));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // instruction load; the capture pattern comes out first
  task automatic ir(input logic [3:0] c);
    tester.scan(1'b1, 4, {60'h0, c}, r);
    chk(r[3:0], IR_CAPTURE);
  endtask

  task automatic rnd();
    d = {$random(seed), $random(seed)};
  endtask

  // hang guard, well beyond the expected run
  initial begin
    #300000;
    error_cnt++;
    test_done();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    {pad_in, sys_out, sys_oe, c_ack, c_stp, c_trg, brk} = '0;
    // system logic drives its pins, so a float code has something to turn off
    sys_oe = 1'b1;
    dstat = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    tester.tick(1'b0, 1'b1);
    // identity straight out of reset, twice: shifting in must not alter it
    repeat (2) begin
      rnd();
      tester.scan(1'b0, 32, d, q);
      chk(q[31:0], ID_VAL);
    end
    // float, reserved and bypass codes all give a one-bit path
    for (int c = 3; c < 16; c++) begin
      if (c != 5) begin
        ir(c[3:0]);
        rnd();
        tester.scan(1'b0, 8, d, q);
        chk(q[7:0], {d[6:0], BYPASS_CAPTURE});
        chk(tester.oe_cnt, 8);
        chk(pad_oe, {NO{c != 3}});
      end
    end
    // debug path: status out, command in, extra pins live
    rnd();
    @(posedge clk);
    dstat <= d[DBG_W-1:0];
    {c_ack, c_stp, c_trg, brk} <= 4'hf;
    ir(IR_DEBUG);
    rnd();
    tester.scan(1'b0, DBG_W, d, q);
    chk(q[DBG_W-1:0], dstat);
    chk(dcmd, d[DBG_W-1:0]);
    chk({ack, ack_oe, stp, stp_oe, trg, trg_oe, dbrk}, 7'h7f);
    // boundary: sample and preload, then drive the preload under external test
    rnd();
    @(posedge clk);
    pad_in <= d[NI-1:0];
    sys_out <= d[NI+NO-1:NI];
    ir(IR_SAMPLE);
    rnd();
    d[2*L-1] = 1'b0;
    tester.scan(1'b0, 2*L, d, q);
    chk(q[L-1:0], {~sys_oe, sys_out, pad_in});
    chk(q[2*L-1:L], d[L-1:0]);
    chk(pad_out, sys_out);
    ir(IR_EXTEST);
    chk(pad_out, d[L+NI+NO-1:L+NI]);
    chk(pad_oe, {NO{1'b1}});
    chk(sys_in, pad_in);
    // test reset in mid-run brings back identity read
    tester.pulse_reset();
    tester.tick(1'b0, 1'b1);
    tester.scan(1'b0, 32, d, q);
    chk(q[31:0], ID_VAL);
    test_done();
  end
endmodule
